// >>> rtl/adc_ctl_pkg.sv
// constants and carrier types for the converter control and status registers
package adc_ctl_pkg;

	// register byte offsets
	localparam logic [7:0] OFS_FLAGS = 8'h00;
	localparam logic [7:0] OFS_IEN = 8'h04;
	localparam logic [7:0] OFS_CTRL = 8'h08;

	// status and enable bit positions
	localparam int BIT_READY = 0;
	localparam int BIT_SMP_END = 1;
	localparam int BIT_CONV_END = 2;
	localparam int BIT_SEQ_END = 3;
	localparam int BIT_OVERRUN = 4;
	localparam int BIT_WDOG = 7;
	localparam logic [7:0] FLAG_MASK = 8'h9f;

	// control bit positions
	localparam int BIT_ENABLE = 0;
	localparam int BIT_DISABLE = 1;
	localparam int BIT_START = 2;
	localparam int BIT_STOP = 4;
	localparam int BIT_CAL = 31;

	// values after reset
	localparam logic [7:0] FLAGS_RESET = 8'h00;
	localparam logic [7:0] IEN_RESET = 8'h00;

	// one-cycle event pulses from the conversion core
	typedef struct packed {
		logic ready;
		logic sampling_end;
		logic conversion_end;
		logic sequence_end;
		logic watchdog;
		logic disabled;
		logic halted;
		logic cal_done;
	} core_events_t;

	// command levels toward the conversion core
	typedef struct packed {
		logic cal;
		logic stop;
		logic start;
		logic disable_cmd;
		logic enable;
	} ctrl_t;

	localparam ctrl_t CTRL_RESET = '{default: 1'b0};

endpackage

// >>> rtl/adc_status_irq_control_regs.sv
// wishbone register block: event flags, interrupt enables and converter commands
//
// Implementation choice: the Wishbone interface to the registers.
`timescale 1ns/100ps

module adc_status_irq_control_regs import adc_ctl_pkg::*; #(
	parameter int ADDR_W = 4
) (
	// clock and reset
	input wire logic clk,
	input wire logic reset,
	// wishbone classic slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [ADDR_W-1:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// conversion core
	input wire core_events_t core_ev,
	output ctrl_t cmd,
	// interrupt
	output logic irq
);

	// elaboration check: the map needs offsets up to 0x08
	if (ADDR_W < 4 || ADDR_W > 8) begin : g_addr_check
		$error("ADDR_W must lie between 4 and 8");
	end

	typedef struct packed {
		logic [7:0] flags;
		logic [7:0] ien;
		ctrl_t ctrl;
		logic ack;
		logic [31:0] rdata;
		logic irq;
	} state_t;

	localparam state_t STATE_RESET = '{
		flags: FLAGS_RESET,
		ien: IEN_RESET,
		ctrl: CTRL_RESET,
		ack: 1'b0,
		rdata: 32'h0000_0000,
		irq: 1'b0
	};

	state_t st;
	state_t next_st;

	// control bits placed at their register positions
	function automatic logic [31:0] ctrl_word(input ctrl_t c);
		logic [31:0] w;
		w = 32'h0000_0000;
		w[BIT_ENABLE] = c.enable;
		w[BIT_DISABLE] = c.disable_cmd;
		w[BIT_START] = c.start;
		w[BIT_STOP] = c.stop;
		w[BIT_CAL] = c.cal;
		return w;
	endfunction

	// byte enables widened to a bit mask
	function automatic logic [31:0] lane_mask(input logic [3:0] sel);
		logic [31:0] m;
		m = 32'h0000_0000;
		for (int i = 0; i < 4; i++) begin
			m[i*8 +: 8] = {8{sel[i]}};
		end
		return m;
	endfunction

	// does the bus address hit a given byte offset
	function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] ofs);
		// size cast pads narrow buses and avoids a zero-width replication at ADDR_W of 8
		return 8'({a[ADDR_W-1:2], 2'b00}) == ofs;
	endfunction

	logic req;
	logic wr;
	logic [31:0] wd;
	logic [7:0] ev_set;

	assign req = wb_cyc_i & wb_stb_i;
	// a write lands on the edge where the master sees ack
	assign wr = req & wb_we_i & st.ack;
	assign wd = wb_dat_i & lane_mask(wb_sel_i);

	// hardware event vector at flag positions
	always_comb begin
		ev_set = 8'h00;
		ev_set[BIT_READY] = core_ev.ready;
		ev_set[BIT_SMP_END] = core_ev.sampling_end;
		ev_set[BIT_CONV_END] = core_ev.conversion_end;
		ev_set[BIT_SEQ_END] = core_ev.sequence_end;
		ev_set[BIT_OVERRUN] = core_ev.conversion_end & st.flags[BIT_CONV_END];
		ev_set[BIT_WDOG] = core_ev.watchdog;
	end

	// next state
	always_comb begin
		next_st = st;
		next_st.ack = req & ~st.ack;

		// write one to clear; an event in the same cycle wins
		if (wr && hit(wb_adr_i, OFS_FLAGS)) begin
			next_st.flags = st.flags & ~wd[7:0];
		end
		next_st.flags = (next_st.flags | ev_set) & FLAG_MASK;

		// enables frozen while a conversion runs
		if (wr && hit(wb_adr_i, OFS_IEN) && !st.ctrl.start) begin
			next_st.ien = wd[7:0] & FLAG_MASK;
		end

		// hardware clears the command bits as the core reports completion
		if (core_ev.disabled) begin
			next_st.ctrl.enable = 1'b0;
			next_st.ctrl.disable_cmd = 1'b0;
		end
		if (core_ev.halted) begin
			next_st.ctrl.start = 1'b0;
			next_st.ctrl.stop = 1'b0;
		end
		if (core_ev.cal_done) begin
			next_st.ctrl.cal = 1'b0;
		end

		// software sets only; each set is judged against the current register
		if (wr && hit(wb_adr_i, OFS_CTRL)) begin
			if (wd[BIT_ENABLE] && ctrl_word(st.ctrl) == 32'h0000_0000) begin
				next_st.ctrl.enable = 1'b1;
			end
			if (wd[BIT_DISABLE] && st.ctrl.enable && !st.ctrl.start) begin
				next_st.ctrl.disable_cmd = 1'b1;
			end
			if (wd[BIT_START] && st.ctrl.enable && !st.ctrl.disable_cmd) begin
				next_st.ctrl.start = 1'b1;
			end
			if (wd[BIT_STOP] && st.ctrl.start && !st.ctrl.disable_cmd) begin
				next_st.ctrl.stop = 1'b1;
			end
			if (wd[BIT_CAL] && !st.ctrl.enable) begin
				next_st.ctrl.cal = 1'b1;
			end
		end

		// read data captured with the ack; unmapped reads return zero
		next_st.rdata = 32'h0000_0000;
		if (req && !st.ack && !wb_we_i) begin
			if (hit(wb_adr_i, OFS_FLAGS)) begin
				next_st.rdata = {24'h00_0000, st.flags};
			end else if (hit(wb_adr_i, OFS_IEN)) begin
				next_st.rdata = {24'h00_0000, st.ien};
			end else if (hit(wb_adr_i, OFS_CTRL)) begin
				next_st.rdata = ctrl_word(st.ctrl);
			end
		end

		// level interrupt from next values so it moves with the flags
		next_st.irq = |(next_st.flags & next_st.ien);
	end

	// state register
	always_ff @(posedge clk) begin
		if (reset) begin
			st <= STATE_RESET;
		end else begin
			st <= next_st;
		end
	end

	// outputs straight from the state register
	assign wb_dat_o = st.rdata;
	assign wb_ack_o = st.ack;
	assign cmd = st.ctrl;
	assign irq = st.irq;

	// checks
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (reset);

	sequence ctrl_write_s;
		wb_cyc_i && wb_stb_i && wb_we_i && st.ack && hit(wb_adr_i, OFS_CTRL);
	endsequence

	sequence ien_write_s;
		wb_cyc_i && wb_stb_i && wb_we_i && st.ack && hit(wb_adr_i, OFS_IEN);
	endsequence

	ready_set_a: assert property (core_ev.ready |=> st.flags[BIT_READY])
		else $error("ready flag not set");
	smp_set_a: assert property (core_ev.sampling_end |=> st.flags[BIT_SMP_END])
		else $error("sampling end flag not set");
	conv_set_a: assert property (core_ev.conversion_end |=> st.flags[BIT_CONV_END])
		else $error("conversion end flag not set");
	seq_set_a: assert property (core_ev.sequence_end |=> st.flags[BIT_SEQ_END])
		else $error("sequence end flag not set");
	overrun_set_a: assert property (
		core_ev.conversion_end && st.flags[BIT_CONV_END] |=> st.flags[BIT_OVERRUN])
		else $error("overrun not raised");
	overrun_cause_a: assert property ($rose(st.flags[BIT_OVERRUN]) |->
		$past(core_ev.conversion_end) && $past(st.flags[BIT_CONV_END]))
		else $error("overrun set without cause");
	wdog_set_a: assert property (core_ev.watchdog |=> st.flags[BIT_WDOG])
		else $error("watchdog flag not set");
	reserved_zero_a: assert property ((st.flags & ~FLAG_MASK) == 8'h00)
		else $error("reserved status bit set");
	flag_hold_a: assert property ($fell(st.flags[BIT_SMP_END]) |->
		$past(wr) && $past(hit(wb_adr_i, OFS_FLAGS)) && $past(wd[BIT_SMP_END]))
		else $error("flag cleared without write");
	ien_write_a: assert property (ien_write_s ##0 !st.ctrl.start |=>
		st.ien == ($past(wd[7:0]) & FLAG_MASK))
		else $error("enable write lost");
	ien_frozen_a: assert property (st.ctrl.start |=> $stable(st.ien))
		else $error("enables changed during conversion");
	irq_level_a: assert property (st.irq == |(st.flags & st.ien))
		else $error("interrupt does not match flags");
	enable_guard_a: assert property ($rose(st.ctrl.enable) |->
		$past(ctrl_word(st.ctrl)) == 32'h0000_0000)
		else $error("enable set while control busy");
	enable_clear_a: assert property ($fell(st.ctrl.enable) |-> $past(core_ev.disabled))
		else $error("enable cleared without hardware");
	disable_set_a: assert property (ctrl_write_s ##0
		wd[BIT_DISABLE] && st.ctrl.enable && !st.ctrl.start && !core_ev.disabled
		|=> st.ctrl.disable_cmd)
		else $error("disable command lost");
	disable_guard_a: assert property ($rose(st.ctrl.disable_cmd) |->
		$past(st.ctrl.enable) && !$past(st.ctrl.start))
		else $error("disable set against guard");
	start_guard_a: assert property ($rose(st.ctrl.start) |->
		$past(st.ctrl.enable) && !$past(st.ctrl.disable_cmd))
		else $error("start set against guard");
	start_clear_a: assert property ($fell(st.ctrl.start) |-> $past(core_ev.halted))
		else $error("start cleared without hardware");
	stop_guard_a: assert property ($rose(st.ctrl.stop) |->
		$past(st.ctrl.start) && !$past(st.ctrl.disable_cmd))
		else $error("stop set against guard");
	stop_clear_a: assert property ($fell(st.ctrl.stop) |-> $past(core_ev.halted))
		else $error("stop cleared without hardware");
	cal_guard_a: assert property ($rose(st.ctrl.cal) |-> !$past(st.ctrl.enable))
		else $error("calibration set while enabled");
	cal_clear_a: assert property ($fell(st.ctrl.cal) |-> $past(core_ev.cal_done))
		else $error("calibration cleared without done");
	zero_write_a: assert property (ctrl_write_s ##0 wd == 32'h0000_0000 &&
		core_ev == '0 |=> st.ctrl == $past(st.ctrl))
		else $error("zero write changed control");
	ack_once_a: assert property (st.ack |=> !st.ack)
		else $error("ack held two cycles");

	// bus timing: one wait state, read data only beside its ack
	sequence flags_write_s;
		wb_cyc_i && wb_stb_i && wb_we_i && st.ack && hit(wb_adr_i, OFS_FLAGS);
	endsequence

	sequence read_req_s;
		wb_cyc_i && wb_stb_i && !wb_we_i && !st.ack;
	endsequence

	ack_answer_a: assert property (req && !st.ack |=> st.ack)
		else $error("request not answered");
	ack_cause_a: assert property (st.ack |-> $past(req))
		else $error("ack without request");
	ack_idle_a: assert property (!req |=> !st.ack)
		else $error("ack with no request");
	rdata_idle_a: assert property (!st.ack |-> st.rdata == 32'h0000_0000)
		else $error("read data outside ack");
	write_rdata_a: assert property (st.ack && $past(wb_we_i) |-> st.rdata == 32'h0000_0000)
		else $error("read data on a write");
	flags_read_a: assert property (read_req_s ##0 hit(wb_adr_i, OFS_FLAGS) |=>
		st.rdata == {24'h00_0000, $past(st.flags)})
		else $error("flag read wrong");
	ien_read_a: assert property (read_req_s ##0 hit(wb_adr_i, OFS_IEN) |=>
		st.rdata == {24'h00_0000, $past(st.ien)})
		else $error("enable read wrong");
	ctrl_read_a: assert property (read_req_s ##0 hit(wb_adr_i, OFS_CTRL) |=>
		st.rdata == ctrl_word($past(st.ctrl)))
		else $error("control read wrong");
	unmapped_read_a: assert property (read_req_s ##0 !hit(wb_adr_i, OFS_FLAGS) &&
		!hit(wb_adr_i, OFS_IEN) && !hit(wb_adr_i, OFS_CTRL) |=> st.rdata == 32'h0000_0000)
		else $error("unmapped read not zero");

	// write one clears a flag unless its event lands on the same edge
	ready_clear_a: assert property (flags_write_s ##0
		wd[BIT_READY] && !ev_set[BIT_READY] |=> !st.flags[BIT_READY])
		else $error("ready flag not cleared");
	smp_clear_a: assert property (flags_write_s ##0
		wd[BIT_SMP_END] && !ev_set[BIT_SMP_END] |=> !st.flags[BIT_SMP_END])
		else $error("sampling end flag not cleared");
	conv_clear_a: assert property (flags_write_s ##0
		wd[BIT_CONV_END] && !ev_set[BIT_CONV_END] |=> !st.flags[BIT_CONV_END])
		else $error("conversion end flag not cleared");
	seq_clear_a: assert property (flags_write_s ##0
		wd[BIT_SEQ_END] && !ev_set[BIT_SEQ_END] |=> !st.flags[BIT_SEQ_END])
		else $error("sequence end flag not cleared");
	overrun_clear_a: assert property (flags_write_s ##0
		wd[BIT_OVERRUN] && !ev_set[BIT_OVERRUN] |=> !st.flags[BIT_OVERRUN])
		else $error("overrun flag not cleared");
	wdog_clear_a: assert property (flags_write_s ##0
		wd[BIT_WDOG] && !ev_set[BIT_WDOG] |=> !st.flags[BIT_WDOG])
		else $error("watchdog flag not cleared");

	// flags are sticky: only a write of one takes them down
	ready_hold_a: assert property ($fell(st.flags[BIT_READY]) |->
		$past(wr) && $past(hit(wb_adr_i, OFS_FLAGS)) && $past(wd[BIT_READY]))
		else $error("ready flag cleared without write");
	conv_hold_a: assert property ($fell(st.flags[BIT_CONV_END]) |->
		$past(wr) && $past(hit(wb_adr_i, OFS_FLAGS)) && $past(wd[BIT_CONV_END]))
		else $error("conversion end flag cleared without write");
	seq_hold_a: assert property ($fell(st.flags[BIT_SEQ_END]) |->
		$past(wr) && $past(hit(wb_adr_i, OFS_FLAGS)) && $past(wd[BIT_SEQ_END]))
		else $error("sequence end flag cleared without write");
	overrun_hold_a: assert property ($fell(st.flags[BIT_OVERRUN]) |->
		$past(wr) && $past(hit(wb_adr_i, OFS_FLAGS)) && $past(wd[BIT_OVERRUN]))
		else $error("overrun flag cleared without write");
	wdog_hold_a: assert property ($fell(st.flags[BIT_WDOG]) |->
		$past(wr) && $past(hit(wb_adr_i, OFS_FLAGS)) && $past(wd[BIT_WDOG]))
		else $error("watchdog flag cleared without write");

	// enable register: reserved positions stay zero, changes only by a legal write
	ien_reserved_a: assert property ((st.ien & ~FLAG_MASK) == 8'h00)
		else $error("reserved enable bit set");
	ien_hold_a: assert property ($changed(st.ien) |->
		$past(wr) && $past(hit(wb_adr_i, OFS_IEN)) && !$past(st.ctrl.start))
		else $error("enables changed without legal write");

	// each accepted set lands on the edge of the ack, even against a hardware clear
	enable_set_a: assert property (ctrl_write_s ##0
		wd[BIT_ENABLE] && ctrl_word(st.ctrl) == 32'h0000_0000 |=> st.ctrl.enable)
		else $error("enable command lost");
	start_set_a: assert property (ctrl_write_s ##0
		wd[BIT_START] && st.ctrl.enable && !st.ctrl.disable_cmd |=> st.ctrl.start)
		else $error("start command lost");
	stop_set_a: assert property (ctrl_write_s ##0
		wd[BIT_STOP] && st.ctrl.start && !st.ctrl.disable_cmd |=> st.ctrl.stop)
		else $error("stop command lost");
	cal_set_a: assert property (ctrl_write_s ##0
		wd[BIT_CAL] && !st.ctrl.enable |=> st.ctrl.cal)
		else $error("calibration command lost");

	// hardware clears follow the core's completion pulses
	disabled_clear_a: assert property (core_ev.disabled && !wr |=>
		!st.ctrl.enable && !st.ctrl.disable_cmd)
		else $error("disable completion not applied");
	halted_clear_a: assert property (core_ev.halted && !wr |=>
		!st.ctrl.start && !st.ctrl.stop)
		else $error("halt completion not applied");
	cal_done_clear_a: assert property (core_ev.cal_done && !wr |=> !st.ctrl.cal)
		else $error("calibration completion not applied");
	disable_fall_a: assert property ($fell(st.ctrl.disable_cmd) |-> $past(core_ev.disabled))
		else $error("disable cleared without hardware");
	ctrl_stable_a: assert property (!wr && !core_ev.disabled && !core_ev.halted &&
		!core_ev.cal_done |=> $stable(st.ctrl))
		else $error("control changed without cause");

endmodule

// >>> verification/testbench.sv
// self-checking bench for the converter flag, enable and command registers
`timescale 1ns/100ps

module testbench import adc_ctl_pkg::*;;
	typedef struct packed {
		logic [1:0] op;
		logic [3:0] a;
		logic [31:0] d;
		logic irq;
	} row_t;

	logic clk, reset, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, irq;
	logic [3:0] wb_adr_i, wb_sel_i;
	logic [31:0] wb_dat_i, wb_dat_o, q;
	core_events_t core_ev;
	ctrl_t cmd;
	int n_fail = 0;
	int compares = 0;
	row_t rows[$];

	adc_status_irq_control_regs #(.ADDR_W(4)) adc_status_irq_control_regs_i (.clk(clk),
		.reset(reset), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
		.wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
		.wb_ack_o(wb_ack_o), .core_ev(core_ev), .cmd(cmd), .irq(irq));

	// 40 MHz clock
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	// row builders: write, read with expected word, core event pulse
	function automatic row_t wr(input logic [3:0] a, input logic [31:0] d, input logic i);
		return '{2'h0, a, d, i};
	endfunction
	function automatic row_t rd(input logic [3:0] a, input logic [31:0] d, input logic i);
		return '{2'h1, a, d, i};
	endfunction
	function automatic row_t ev(input logic [31:0] d, input logic i);
		return '{2'h2, 4'h0, d, i};
	endfunction

	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			n_fail++;
			$display("mismatch %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", compares, n_fail);
		if (n_fail == 0 && compares > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask

	// one classic cycle; entered just after a rising edge, waits for ack without assuming latency
	task automatic bus(input logic we, input logic [3:0] a, input logic [31:0] d,
			output logic [31:0] r);
		int n;
		n = 0;
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= a;
		wb_dat_i <= d;
		do begin
			@(posedge clk);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 20);
		if (n >= 20) chk("ack", 32'h0, 32'h1);
		r = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		@(posedge clk);
	endtask

	task automatic pulse(input logic [7:0] e);
		core_ev <= core_events_t'(e);
		@(posedge clk);
		core_ev <= core_events_t'(8'h00);
		@(posedge clk);
	endtask

	// reads every register expecting zero and checks that the command levels are all zero
	task automatic all_zero();
		bus(1'b0, 4'h0, 32'h0, q);
		chk("flags", q, 32'h0);
		bus(1'b0, 4'h4, 32'h0, q);
		chk("enables", q, 32'h0);
		bus(1'b0, 4'h8, 32'h0, q);
		chk("control", q, 32'h0);
		chk("cmd", {27'h0, cmd}, 32'h0);
	endtask

	// main sequence
	initial begin
		reset = 1'b1;
		{wb_cyc_i, wb_stb_i, wb_we_i} = 3'h0;
		wb_adr_i = 4'h0;
		wb_sel_i = 4'hf;
		wb_dat_i = 32'h0;
		core_ev = core_events_t'(8'h00);
		repeat (4) @(posedge clk);
		reset <= 1'b0;
		@(posedge clk);
		rows = '{rd(4'h0, 8'h0, 0), rd(4'h4, 8'h0, 0), rd(4'h8, 8'h0, 0),
			rd(4'hc, 8'h0, 0), wr(4'hc, 32'hffffffff, 0), rd(4'h4, 8'h0, 0),
			wr(4'h4, 32'hffffffff, 0), rd(4'h4, 8'h9f, 0), ev(8'hf8, 1),
			rd(4'h0, 8'h8f, 1), ev(8'h20, 1), rd(4'h0, 8'h9f, 1),
			wr(4'h0, 8'h04, 1), rd(4'h0, 8'h9b, 1), wr(4'h0, 32'hffffffff, 0),
			rd(4'h0, 8'h0, 0), wr(4'h8, 32'h80000000, 0), wr(4'h8, 8'h01, 0),
			rd(4'h8, 32'h80000000, 0), ev(8'h01, 0), wr(4'h8, 8'h02, 0),
			wr(4'h8, 8'h04, 0), wr(4'h8, 8'h10, 0), rd(4'h8, 8'h0, 0),
			wr(4'h8, 8'h01, 0), wr(4'h8, 8'h00, 0), wr(4'h8, 32'h80000000, 0),
			rd(4'h8, 8'h01, 0), wr(4'h8, 8'h04, 0), wr(4'h4, 8'h00, 0),
			rd(4'h4, 8'h9f, 0), wr(4'h8, 8'h02, 0), rd(4'h8, 8'h05, 0),
			wr(4'h8, 8'h10, 0), rd(4'h8, 8'h15, 0), ev(8'h02, 0),
			rd(4'h8, 8'h01, 0), wr(4'h4, 8'h10, 0), rd(4'h4, 8'h10, 0),
			ev(8'h20, 0), rd(4'h0, 8'h04, 0), ev(8'h20, 1), rd(4'h0, 8'h14, 1),
			wr(4'h8, 8'h02, 1), rd(4'h8, 8'h03, 1), ev(8'h04, 1),
			rd(4'h8, 8'h0, 1), wr(4'h0, 8'hff, 0)};
		foreach (rows[k]) begin
			case (rows[k].op)
				2'h0: bus(1'b1, rows[k].a, rows[k].d, q);
				2'h1: begin
					bus(1'b0, rows[k].a, 32'h0, q);
					chk("read", q, rows[k].d);
					if (rows[k].a == 4'h8) begin
						chk("cmd", {27'h0, cmd}, {27'h0, q[31], q[4], q[2], q[1], q[0]});
					end
				end
				default: pulse(rows[k].d[7:0]);
			endcase
			@(posedge clk);
			chk("irq", {31'h0, irq}, {31'h0, rows[k].irq});
			$display("row %0d done", k);
		end
		// reset in mid-run, with every flag but overrun, all enables and the enable command set
		bus(1'b1, 4'h4, 32'h9f, q);
		pulse(8'hf8);
		bus(1'b1, 4'h8, 32'h1, q);
		reset <= 1'b1;
		repeat (4) @(posedge clk);
		reset <= 1'b0;
		@(posedge clk);
		all_zero();
		chk("irq", {31'h0, irq}, 32'h0);
		$display("mid-run reset done");
		// conversion end arriving on the same edge as its clear: the event wins
		fork
			bus(1'b1, 4'h0, 32'h4, q);
			begin
				@(posedge clk);
				core_ev <= core_events_t'(8'h20);
				@(posedge clk);
				core_ev <= core_events_t'(8'h00);
			end
		join
		bus(1'b0, 4'h0, 32'h0, q);
		chk("flags", q, 32'h4);
		$display("set against clear done");
		report_and_stop();
	end

	// watchdog: the table needs well under 1000 cycles
	initial begin
		repeat (5000) @(posedge clk);
		n_fail++;
		report_and_stop();
	end
endmodule
